// ===== hdl/psum_pkg.sv
// constants and types shared by the phy status summary block
package psum_pkg;

    // register indices; byte address on apb is four times the index
    localparam logic [5:0] PSUM_IDX_BASIC_MODE_STATUS_REG = 6'h01;
    localparam logic [5:0] PSUM_IDX_AUTONEG_EXPANSION_REG = 6'h06;
    localparam logic [5:0] PSUM_IDX_SUMMARY = 6'h10;
    localparam logic [5:0] PSUM_IDX_CAUSE = 6'h12;
    localparam logic [5:0] PSUM_IDX_IRQ_STATUS = 6'h20;
    localparam logic [5:0] PSUM_IDX_IRQ_MASK = 6'h21;

    // summary register field positions
    localparam int PSUM_SUM_PAGE = 8;
    localparam int PSUM_SUM_PEND = 7;
    localparam int PSUM_SUM_RFAULT = 6;
    localparam int PSUM_SUM_JABBER = 5;
    localparam int PSUM_SUM_ANDONE = 4;
    localparam int PSUM_SUM_LOOP = 3;

    // autoneg expansion: page received flag
    localparam int PSUM_AUTONEG_EXPANSION_REG_PAGE = 1;

    // basic mode status: jabber, remote fault, autoneg complete
    localparam int PSUM_BASIC_MODE_STATUS_REG_JABBER = 1;
    localparam int PSUM_BASIC_MODE_STATUS_REG_RFAULT = 4;
    localparam int PSUM_BASIC_MODE_STATUS_REG_ANDONE = 5;

    // cause, irq status and irq mask share this layout
    localparam int PSUM_NCAUSE = 4;
    localparam int PSUM_CAUSE_PAGE = 0;
    localparam int PSUM_CAUSE_RFAULT = 1;
    localparam int PSUM_CAUSE_JABBER = 2;
    localparam int PSUM_CAUSE_ANDONE = 3;

    // values after reset
    localparam logic [31:0] PSUM_RDATA_RESET = 32'h0000_0000;
    localparam logic [PSUM_NCAUSE-1:0] PSUM_MASK_RESET = 4'h0;

    // status sources from the phy's own state machines
    typedef struct packed {
        logic page_rx;      // pulse: new link code word page arrived
        logic remote_fault; // pulse: partner reports remote fault
        logic jabber;       // pulse: jabber condition seen
        logic an_complete;  // level: auto-negotiation complete
        logic loopback;     // level: mii loopback enabled and active
        logic speed_10;     // level: phy runs at 10 mb/s
    } psum_evt_t;

endpackage

// ===== hdl/psum_sticky.sv
// bank of sticky flags, set wins over clear
`timescale 1ns/10ps
module psum_sticky
    import psum_pkg::*;
#(
    parameter int W = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // per-bit set and clear strobes
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    // flag state
    output logic [W-1:0] q
);

    genvar i;

    // one flop per flag; a set in the clearing cycle is kept
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    q[i] <= 1'b0;
                end else if (ce) begin
                    if (set[i]) begin
                        q[i] <= 1'b1;
                    end else if (clr[i]) begin
                        q[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

endmodule

// ===== hdl/psum_irq.sv
// interrupt status (write one to clear), mask and level output
`timescale 1ns/10ps
module psum_irq
    import psum_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // event pulses
    input wire logic [PSUM_NCAUSE-1:0] evt,
    // software writes
    input wire logic wr_status,
    input wire logic wr_mask,
    input wire logic [PSUM_NCAUSE-1:0] wdata,
    // state
    output logic [PSUM_NCAUSE-1:0] status,
    output logic [PSUM_NCAUSE-1:0] mask,
    output logic irq
);

    genvar i;

    // status bits: event sets, written one clears, set wins
    generate
        for (i = 0; i < PSUM_NCAUSE; i++) begin : g_stat
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    status[i] <= 1'b0;
                end else if (ce) begin
                    if (evt[i]) begin
                        status[i] <= 1'b1;
                    end else if (wr_status && wdata[i]) begin
                        status[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // mask register, one enables the bit onto irq
    always_ff @(posedge clk) begin
        if (!resetn) begin
            mask <= PSUM_MASK_RESET;
        end else if (ce && wr_mask) begin
            mask <= wdata;
        end
    end

    // level interrupt while any enabled status bit is set
    assign irq = |(status & mask);

endmodule

// ===== hdl/psum_top.sv
// phy status summary register bank with its read-clear sources
//
// Local design decision: register access over APB.
`timescale 1ns/10ps
module psum_top
    import psum_pkg::*;
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // status sources, same clock
    input wire psum_evt_t evt,
    // interrupt
    output logic irq
);

    // decode
    logic [5:0] idx; // word index of the access
    logic aligned; // low address bits are zero
    logic mapped; // index names a register
    logic setup_ph; // apb setup cycle
    logic acc_ph; // apb access completes this edge
    logic acc_rd; // read completes this edge
    logic acc_wr; // write completes this edge

    // flags
    logic [3:0] flag; // page, pend, rfault, jabber
    logic [3:0] flag_set; // set strobes
    logic [3:0] flag_clr; // clear strobes
    logic [PSUM_NCAUSE-1:0] cause; // read-clear cause latches
    logic [PSUM_NCAUSE-1:0] cause_set; // cause events
    logic [PSUM_NCAUSE-1:0] cause_clr; // cause clears
    logic [PSUM_NCAUSE-1:0] irq_status; // w1c status
    logic [PSUM_NCAUSE-1:0] irq_mask; // mask
    logic an_done_prev; // last autoneg level for edge detect
    logic [15:0] summary_val; // assembled summary word
    logic [31:0] next_rdata; // read mux output

    localparam int F_PAGE = 0;
    localparam int F_PEND = 1;
    localparam int F_RF = 2;
    localparam int F_JAB = 3;

    // apb phase decode; pready follows ce so a frozen block stalls
    assign idx = paddr[7:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign setup_ph = psel && !penable && ce;
    assign acc_ph = psel && penable && ce;
    assign acc_rd = acc_ph && !pwrite;
    assign acc_wr = acc_ph && pwrite;
    assign pready = ce;

    // which indices answer
    always_comb begin
        case (idx)
            PSUM_IDX_BASIC_MODE_STATUS_REG,
            PSUM_IDX_AUTONEG_EXPANSION_REG,
            PSUM_IDX_SUMMARY,
            PSUM_IDX_CAUSE,
            PSUM_IDX_IRQ_STATUS,
            PSUM_IDX_IRQ_MASK: mapped = aligned;
            default: mapped = 1'b0;
        endcase
    end

    // unmapped or misaligned access is flagged in its access cycle
    assign pslverr = psel && penable && !mapped;

    // autoneg rising edge is the completion event
    always_ff @(posedge clk) begin
        if (!resetn) begin
            an_done_prev <= 1'b0;
        end else if (ce) begin
            an_done_prev <= evt.an_complete;
        end
    end

    // cause events
    always_comb begin
        cause_set = '0;
        cause_set[PSUM_CAUSE_PAGE] = evt.page_rx;
        cause_set[PSUM_CAUSE_RFAULT] = evt.remote_fault;
        cause_set[PSUM_CAUSE_JABBER] = evt.jabber && evt.speed_10;
        cause_set[PSUM_CAUSE_ANDONE] = evt.an_complete && !an_done_prev;
    end

    // flag set strobes
    always_comb begin
        flag_set = '0;
        flag_set[F_PAGE] = evt.page_rx;
        flag_set[F_PEND] = |cause_set;
        flag_set[F_RF] = evt.remote_fault;
        // jabber only counts while running at 10 mb/s
        flag_set[F_JAB] = evt.jabber && evt.speed_10;
    end

    // clears only drop bits the completing read actually returned,
    // so an event landing between setup and access is not lost
    always_comb begin
        flag_clr = '0;
        cause_clr = '0;
        if (acc_rd && mapped) begin
            case (idx)
                PSUM_IDX_AUTONEG_EXPANSION_REG: begin
                    flag_clr[F_PAGE] = prdata[PSUM_AUTONEG_EXPANSION_REG_PAGE];
                end
                PSUM_IDX_BASIC_MODE_STATUS_REG: begin
                    flag_clr[F_RF] = prdata[PSUM_BASIC_MODE_STATUS_REG_RFAULT];
                    flag_clr[F_JAB] = prdata[PSUM_BASIC_MODE_STATUS_REG_JABBER];
                end
                PSUM_IDX_CAUSE: begin
                    cause_clr = prdata[PSUM_NCAUSE-1:0];
                    flag_clr[F_PEND] = |prdata[PSUM_NCAUSE-1:0];
                end
                default: begin
                    // summary and others: reading clears nothing
                    flag_clr = '0;
                end
            endcase
        end
    end

    // page, pending, remote fault and jabber latches
    psum_sticky #(
        .W(4)
    ) u_flags (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .set(flag_set),
        .clr(flag_clr),
        .q(flag)
    );

    // interrupt cause latches behind the pending bit
    psum_sticky #(
        .W(PSUM_NCAUSE)
    ) u_cause (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .set(cause_set),
        .clr(cause_clr),
        .q(cause)
    );

    // software interrupt status and mask
    psum_irq u_irq (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .evt(cause_set),
        .wr_status(acc_wr && mapped && idx == PSUM_IDX_IRQ_STATUS &&
            pstrb[0]),
        .wr_mask(acc_wr && mapped && idx == PSUM_IDX_IRQ_MASK && pstrb[0]),
        .wdata(pwdata[PSUM_NCAUSE-1:0]),
        .status(irq_status),
        .mask(irq_mask),
        .irq(irq)
    );

    // summary word; no write path exists, so writes leave it alone
    always_comb begin
        summary_val = '0;
        summary_val[PSUM_SUM_PAGE] = flag[F_PAGE];
        summary_val[PSUM_SUM_PEND] = flag[F_PEND];
        summary_val[PSUM_SUM_RFAULT] = flag[F_RF];
        summary_val[PSUM_SUM_JABBER] = flag[F_JAB];
        summary_val[PSUM_SUM_ANDONE] = evt.an_complete;
        summary_val[PSUM_SUM_LOOP] = evt.loopback;
    end

    // read mux
    always_comb begin
        next_rdata = '0;
        case (idx)
            PSUM_IDX_SUMMARY: next_rdata[15:0] = summary_val;
            PSUM_IDX_AUTONEG_EXPANSION_REG: next_rdata[PSUM_AUTONEG_EXPANSION_REG_PAGE] = flag[F_PAGE];
            PSUM_IDX_BASIC_MODE_STATUS_REG: begin
                next_rdata[PSUM_BASIC_MODE_STATUS_REG_JABBER] = flag[F_JAB];
                next_rdata[PSUM_BASIC_MODE_STATUS_REG_RFAULT] = flag[F_RF];
                next_rdata[PSUM_BASIC_MODE_STATUS_REG_ANDONE] = evt.an_complete;
            end
            PSUM_IDX_CAUSE: next_rdata[PSUM_NCAUSE-1:0] = cause;
            PSUM_IDX_IRQ_STATUS: next_rdata[PSUM_NCAUSE-1:0] = irq_status;
            PSUM_IDX_IRQ_MASK: next_rdata[PSUM_NCAUSE-1:0] = irq_mask;
            default: next_rdata = '0;
        endcase
        if (!mapped) begin
            next_rdata = '0;
        end
    end

    // read data captured in setup and held through the access;
    // the read-clear uses this same snapshot
    always_ff @(posedge clk) begin
        if (!resetn) begin
            prdata <= PSUM_RDATA_RESET;
        end else if (setup_ph && !pwrite) begin
            prdata <= next_rdata;
        end
    end

    // checks

    property p_page_set;
        @(posedge clk) disable iff (!resetn)
        ce && evt.page_rx |=> summary_val[PSUM_SUM_PAGE];
    endproperty
    a_page_set: assert property (p_page_set)
        else $error("page received bit not set");

    property p_page_keep;
        @(posedge clk) disable iff (!resetn)
        acc_rd && idx != PSUM_IDX_AUTONEG_EXPANSION_REG && flag[F_PAGE]
            |=> flag[F_PAGE];
    endproperty
    a_page_keep: assert property (p_page_keep)
        else $error("page bit cleared by wrong read");

    property p_pend_set;
        @(posedge clk) disable iff (!resetn)
        ce && (|cause_set) |=> summary_val[PSUM_SUM_PEND] && (|cause);
    endproperty
    a_pend_set: assert property (p_pend_set)
        else $error("pending bit not set on cause");

    property p_pend_clr;
        @(posedge clk) disable iff (!resetn)
        acc_rd && aligned && idx == PSUM_IDX_CAUSE &&
            prdata[PSUM_NCAUSE-1:0] == cause && !(|cause_set)
            |=> !flag[F_PEND];
    endproperty
    a_pend_clr: assert property (p_pend_clr)
        else $error("cause read did not clear pending");

    property p_rf_set;
        @(posedge clk) disable iff (!resetn)
        ce && evt.remote_fault |=> summary_val[PSUM_SUM_RFAULT];
    endproperty
    a_rf_set: assert property (p_rf_set)
        else $error("remote fault bit not set");

    property p_rf_clr;
        @(posedge clk) disable iff (!resetn)
        setup_ph && !pwrite && aligned && idx == PSUM_IDX_BASIC_MODE_STATUS_REG &&
            flag[F_RF] && !evt.remote_fault ##1
            acc_rd && !evt.remote_fault |=> !flag[F_RF];
    endproperty
    a_rf_clr: assert property (p_rf_clr)
        else $error("status read did not clear remote fault");

    property p_jab_keep;
        @(posedge clk) disable iff (!resetn)
        acc_rd && idx == PSUM_IDX_SUMMARY && flag[F_JAB]
            |=> summary_val[PSUM_SUM_JABBER];
    endproperty
    a_jab_keep: assert property (p_jab_keep)
        else $error("summary read cleared jabber");

    property p_jab_speed;
        @(posedge clk) disable iff (!resetn)
        ce && !flag[F_JAB] && !(evt.jabber && evt.speed_10)
            |=> !flag[F_JAB];
    endproperty
    a_jab_speed: assert property (p_jab_speed)
        else $error("jabber set outside 10 mb/s");

    property p_andone_read;
        @(posedge clk) disable iff (!resetn)
        setup_ph && !pwrite && aligned && idx == PSUM_IDX_SUMMARY
            |=> prdata[PSUM_SUM_ANDONE] == $past(evt.an_complete);
    endproperty
    a_andone_read: assert property (p_andone_read)
        else $error("autoneg status misreported");

    property p_loop_read;
        @(posedge clk) disable iff (!resetn)
        setup_ph && !pwrite && aligned && idx == PSUM_IDX_SUMMARY
            |=> prdata[PSUM_SUM_LOOP] == $past(evt.loopback);
    endproperty
    a_loop_read: assert property (p_loop_read)
        else $error("loopback status misreported");

endmodule

// ===== dv/tb.sv
// self-checking bench for the phy status summary register bank
`timescale 1ns/10ps
module tb
    import psum_pkg::*;
;
    // clock, reset and apb master signals
    logic clk, resetn, ce, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic pready, pslverr, irq;
    psum_evt_t evt; // status sources driven by the bench
    int n_errors, cmp_count;
    // reference model of the latched flags
    logic m_page, m_pend, m_rf, m_jab;
    logic [3:0] m_cause, m_st, m_mask;
    logic [31:0] rd_data; // data taken at the access edge
    logic rd_err;
    logic [31:0] r;

    psum_top dut_u (.clk(clk), .resetn(resetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .evt(evt), .irq(irq));

    // 25 mhz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // count a comparison, report a mismatch at once
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // verdict and end of run, shared with the watchdog
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // one apb transfer; waits on pready, the watchdog bounds the wait
    task automatic apb(input logic wr, input logic [7:0] addr,
            input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // expected summary word from model flags and current levels
    function automatic logic [31:0] exp_sum();
        logic [31:0] v;
        v = 32'h0000_0000;
        v[PSUM_SUM_PAGE] = m_page;
        v[PSUM_SUM_PEND] = m_pend;
        v[PSUM_SUM_RFAULT] = m_rf;
        v[PSUM_SUM_JABBER] = m_jab;
        v[PSUM_SUM_ANDONE] = evt.an_complete;
        v[PSUM_SUM_LOOP] = evt.loopback;
        return v;
    endfunction

    // read a mapped register, compare, then apply the read clears
    task automatic rdc(input logic [5:0] idx);
        logic [31:0] e;
        e = 32'h0000_0000;
        case (idx)
            PSUM_IDX_SUMMARY: e = exp_sum();
            PSUM_IDX_AUTONEG_EXPANSION_REG: e[PSUM_AUTONEG_EXPANSION_REG_PAGE] = m_page;
            PSUM_IDX_BASIC_MODE_STATUS_REG: begin
                e[PSUM_BASIC_MODE_STATUS_REG_JABBER] = m_jab;
                e[PSUM_BASIC_MODE_STATUS_REG_RFAULT] = m_rf;
                e[PSUM_BASIC_MODE_STATUS_REG_ANDONE] = evt.an_complete;
            end
            PSUM_IDX_CAUSE: e[3:0] = m_cause;
            PSUM_IDX_IRQ_STATUS: e[3:0] = m_st;
            default: e[3:0] = m_mask;
        endcase
        apb(1'b0, {idx, 2'b00}, 32'h0000_0000);
        chk(rd_data, e);
        chk({31'h0, rd_err}, 32'h0000_0000);
        if (idx == PSUM_IDX_AUTONEG_EXPANSION_REG) m_page = 1'b0;
        if (idx == PSUM_IDX_BASIC_MODE_STATUS_REG) begin
            m_rf = 1'b0;
            m_jab = 1'b0;
        end
        // only a nonzero cause read drops the pending flag
        if (idx == PSUM_IDX_CAUSE) begin
            if (m_cause != 4'h0) m_pend = 1'b0;
            m_cause = 4'h0;
        end
    endtask

    // write a register, update the model, check the irq level
    task automatic wrc(input logic [5:0] idx, input logic [31:0] wd);
        apb(1'b1, {idx, 2'b00}, wd);
        if (idx == PSUM_IDX_IRQ_MASK) m_mask = wd[3:0];
        if (idx == PSUM_IDX_IRQ_STATUS) m_st = m_st & ~wd[3:0];
        @(negedge clk);
        chk({31'h0, irq}, {31'h0, |(m_st & m_mask)});
    endtask

    // one-cycle event pulse on evt bit b (5 page, 4 rfault, 3 jabber)
    task automatic pulse(input int b);
        logic hit;
        @(posedge clk);
        // sample speed only after a speed change driven just before settles
        hit = (b != 3) || evt.speed_10;
        evt[b] <= 1'b1;
        @(posedge clk);
        evt[b] <= 1'b0;
        // jabber is dropped outside 10 mb/s
        if (hit) begin
            m_pend = 1'b1;
            m_cause[5 - b] = 1'b1;
            m_st[5 - b] = 1'b1;
        end
        if (b == 5) m_page = 1'b1;
        if (b == 4) m_rf = 1'b1;
        if (b == 3 && hit) m_jab = 1'b1;
    endtask

    // set the two level sources; a rising autoneg done is an event
    task automatic lvl(input logic an, input logic lb);
        @(posedge clk);
        if (an && !evt.an_complete) begin
            m_cause[3] = 1'b1;
            m_st[3] = 1'b1;
            m_pend = 1'b1;
        end
        evt.an_complete <= an;
        evt.loopback <= lb;
        // extra edge lets a registered edge detector catch up
        @(posedge clk);
    endtask

    // synchronous reset held for three edges, model cleared
    task automatic do_reset();
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        {m_page, m_pend, m_rf, m_jab} = 4'h0;
        {m_cause, m_st, m_mask} = 12'h000;
    endtask

    // watchdog: the whole sequence needs well under a thousand edges
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        end_of_test();
    end

    // main sequence
    initial begin
        void'($urandom(52827));
        ce = 1'b1;
        {psel, penable, pwrite} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'hF;
        evt = '0;
        n_errors = 0;
        cmp_count = 0;
        do_reset();
        rdc(PSUM_IDX_SUMMARY);
        repeat (4) begin
            wrc(PSUM_IDX_SUMMARY, $urandom());
            rdc(PSUM_IDX_SUMMARY);
        end
        $display("test reset_and_writes done");
        // random levels, then both corners
        repeat (8) begin
            r = $urandom();
            lvl(r[0], r[1]);
            rdc(PSUM_IDX_SUMMARY);
        end
        lvl(1'b1, 1'b1);
        rdc(PSUM_IDX_SUMMARY);
        lvl(1'b0, 1'b0);
        rdc(PSUM_IDX_CAUSE);
        rdc(PSUM_IDX_SUMMARY);
        $display("test levels done");
        // page flag survives summary reads, clears on expansion read
        pulse(5);
        rdc(PSUM_IDX_SUMMARY);
        rdc(PSUM_IDX_SUMMARY);
        rdc(PSUM_IDX_AUTONEG_EXPANSION_REG);
        rdc(PSUM_IDX_SUMMARY);
        rdc(PSUM_IDX_CAUSE);
        rdc(PSUM_IDX_SUMMARY);
        $display("test page done");
        // frozen block: pready low, a page event ignored, state kept
        @(posedge clk);
        ce <= 1'b0;
        evt.page_rx <= 1'b1;
        @(posedge clk);
        evt.page_rx <= 1'b0;
        @(negedge clk);
        chk({31'h0, pready}, 32'h0000_0000);
        @(posedge clk);
        ce <= 1'b1;
        @(negedge clk);
        chk({31'h0, pready}, 32'h0000_0001);
        rdc(PSUM_IDX_SUMMARY);
        $display("test clock_enable done");
        // remote fault cleared by basic status read and by reset
        pulse(4);
        rdc(PSUM_IDX_SUMMARY);
        rdc(PSUM_IDX_BASIC_MODE_STATUS_REG);
        rdc(PSUM_IDX_SUMMARY);
        pulse(4);
        do_reset();
        rdc(PSUM_IDX_SUMMARY);
        $display("test remote_fault done");
        // jabber at 10 mb/s, then ignored at 100 mb/s
        for (int s = 1; s >= 0; s--) begin
            @(posedge clk);
            evt.speed_10 <= s[0];
            pulse(3);
            rdc(PSUM_IDX_SUMMARY);
            rdc(PSUM_IDX_SUMMARY);
            rdc(PSUM_IDX_BASIC_MODE_STATUS_REG);
            rdc(PSUM_IDX_SUMMARY);
        end
        $display("test jabber done");
        // interrupt: raise, mask, unmask at random, clear by write one
        pulse(5);
        pulse(4);
        rdc(PSUM_IDX_IRQ_STATUS);
        wrc(PSUM_IDX_IRQ_MASK, 32'h0000_0000);
        repeat (4) begin
            wrc(PSUM_IDX_IRQ_MASK, $urandom_range(15));
            rdc(PSUM_IDX_IRQ_MASK);
        end
        wrc(PSUM_IDX_IRQ_MASK, 32'h0000_000F);
        wrc(PSUM_IDX_IRQ_STATUS, 32'h0000_0001);
        wrc(PSUM_IDX_IRQ_STATUS, 32'h0000_000F);
        rdc(PSUM_IDX_IRQ_STATUS);
        rdc(PSUM_IDX_SUMMARY);
        $display("test interrupt done");
        // unmapped and misaligned addresses are refused
        apb(1'b0, 8'hFC, 32'h0000_0000);
        chk({31'h0, rd_err}, 32'h0000_0001);
        chk(rd_data, 32'h0000_0000);
        apb(1'b1, 8'h41, 32'hFFFF_FFFF);
        chk({31'h0, rd_err}, 32'h0000_0001);
        rdc(PSUM_IDX_SUMMARY);
        $display("test refused_access done");
        end_of_test();
    end
endmodule
